// ---- core/sqrc_map.svh ----
`ifndef SQRC_MAP_SVH
`define SQRC_MAP_SVH

// Default width of the control outputs carried by one microword, below the enable bit.
`define SQRC_OUT_W        16
// Return stack geometry.
`define SQRC_STACK_DEPTH  15
`define SQRC_STACK_W      8
// Loop counter width and its value after a clear.
`define SQRC_LOOP_W       8
`define SQRC_LOOP_RST     8'h00
// Sampled low edges that end in supervisor mode or in an undefined state.
`define SQRC_SUPER_EDGES  2'h1
`define SQRC_UNDEF_EDGES  2'h2
// Count of the last low edge before the clear state; the next low edge makes the clear.
`define SQRC_CLEAR_LAST   2'h2
// Count of the edge after release that comes just before the edge on which the boot word is finally replaced.
`define SQRC_HOLD_LAST    2'h2
// Level of the synchronised reset pin while the pin is released.
`define SQRC_PIN_IDLE     1'h1

`endif

// ---- core/sqrc_pkg.sv ----
package sqrc_pkg;

	typedef enum logic [2:0] {
		sqrc_st_run   = 3'b000,
		sqrc_st_count = 3'b001,
		sqrc_st_clear = 3'b010,
		sqrc_st_hold  = 3'b011,
		sqrc_st_super = 3'b100
	} sqrc_state_type;

endpackage

// ---- core/sqrc_stack.sv ----
`timescale 1ns/1ps
`include "sqrc_map.svh"

module sqrc_stack #(
	parameter int DEPTH = `SQRC_STACK_DEPTH,
	parameter int WIDTH = `SQRC_STACK_W,
	parameter int PW    = $clog2(DEPTH + 1)
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic             flush,
	input  wire logic             push,
	input  wire logic             pop,
	input  wire logic [WIDTH-1:0] wdata,
	output logic      [WIDTH-1:0] top,
	output logic      [PW-1:0]    depth
);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0]    depth_q;
	logic [PW-1:0]    depth_d;
	logic [WIDTH-1:0] top_q;

	wire             full      = (depth_q == PW'(DEPTH));
	wire             empty     = (depth_q == '0);
	wire             do_push   = push && !flush;
	wire             do_pop    = pop && !push && !flush && !empty;
	// A push onto a full stack overwrites the top entry and leaves the rest alone.
	wire [PW-1:0]    wr_idx    = full ? PW'(DEPTH - 1) : depth_q;
	wire [PW-1:0]    below_idx = depth_q - PW'(2);
	// Popping the last entry exposes zeros, so an empty stack reads as zero.
	wire [WIDTH-1:0] below     = (depth_q > PW'(1)) ? mem[below_idx] : '0;

	assign depth_d = flush ? '0 :
		(do_push && !full) ? depth_q + PW'(1) :
		do_pop ? depth_q - PW'(1) : depth_q;

	genvar i;
	generate
		for (i = 0; i < DEPTH; i++) begin : g_entry
			always_ff @(posedge core_clk) begin
				if (do_push && wr_idx == PW'(i)) begin
					mem[i] <= wdata;
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			depth_q <= '0;
			top_q   <= '0;
		end else begin
			depth_q <= depth_d;
			top_q   <= flush ? '0 : do_push ? wdata : do_pop ? below : top_q;
		end
	end

	assign top   = top_q;
	assign depth = depth_q;

	AST_FULL_PUSH_OVERWRITES: assert property (
		@(posedge core_clk) disable iff (rst)
		(full && push && !flush) |=> (depth_q == PW'(DEPTH)) && (top_q == $past(wdata)))
		else $error("push on a full stack changed the depth or lost the data");

	AST_EMPTY_POP_ZERO: assert property (
		@(posedge core_clk) disable iff (rst)
		(empty && pop && !push) |=> (top_q == '0) && (depth_q == '0))
		else $error("pop from an empty stack did not read zero");

endmodule

// ---- core/sqrc_reset_ctl.sv ----
`timescale 1ns/1ps
`include "sqrc_map.svh"

// Operation
// - Microword enable bit drives or floats outputs.
// - Valid clear empties stack, zeroes counter; a fourth low edge boots.
// - One low edge enters supervisor mode.
// - Two low edges: undefined, no clear done.
// - Boot outputs: fourth low edge to third high.
// - Reset brings cascaded sequencers into step.
// - Cascading adds no extra cycle of delay.
// - Return stack is fifteen eight-bit LIFO entries.
// - Eight-bit loop counter counts down, stops zero.
module sqrc_reset_ctl #(
	parameter int OUT_W   = `SQRC_OUT_W,
	parameter int STACK_D = `SQRC_STACK_DEPTH,
	parameter int STACK_W = `SQRC_STACK_W,
	parameter int LOOP_W  = `SQRC_LOOP_W,
	parameter int SP_W    = $clog2(STACK_D + 1)
) (
	input  wire logic             core_clk,
	input  wire logic             rst,
	input  wire logic             master_clear_low,
	input  wire logic [OUT_W:0]   boot_word,
	input  wire logic [OUT_W:0]   next_word,
	input  wire logic             stack_push,
	input  wire logic             stack_pop,
	input  wire logic [STACK_W-1:0] stack_wdata,
	input  wire logic             loop_load,
	input  wire logic [LOOP_W-1:0] loop_value,
	input  wire logic             loop_dec,
	output logic      [OUT_W-1:0] ctl_out,
	output logic      [OUT_W-1:0] ctl_oe,
	output logic      [STACK_W-1:0] stack_top,
	output logic      [SP_W-1:0]  stack_depth,
	output logic      [LOOP_W-1:0] loop_down_counter,
	output logic                  loop_zero,
	output logic                  supervisor_mode,
	output logic                  undefined_state,
	output logic                  clear_active
);

	logic                  pin_meta_q;
	logic                  pin_sync_q;
	sqrc_pkg::sqrc_state_type state_q;
	sqrc_pkg::sqrc_state_type state_d;
	logic [1:0]            low_cnt_q;
	logic [1:0]            low_cnt_d;
	logic [1:0]            rel_cnt_q;
	logic [1:0]            rel_cnt_d;
	logic                  super_q;
	logic                  super_d;
	logic                  undef_q;
	logic                  undef_d;
	logic [OUT_W:0]        pipe_q;
	logic [OUT_W:0]        pipe_d;
	logic [LOOP_W-1:0]     loop_down_counter_q;
	logic [LOOP_W-1:0]     loop_down_counter_d;

	// Every cascaded part sees the pin through the same two stages, so all of them step together.
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pin_meta_q <= `SQRC_PIN_IDLE;
			pin_sync_q <= `SQRC_PIN_IDLE;
		end else begin
			pin_meta_q <= master_clear_low;
			pin_sync_q <= pin_meta_q;
		end
	end

	wire low_s      = !pin_sync_q;
	wire in_run     = (state_q == sqrc_pkg::sqrc_st_run);
	wire in_count   = (state_q == sqrc_pkg::sqrc_st_count);
	wire in_clear   = (state_q == sqrc_pkg::sqrc_st_clear);
	wire in_hold    = (state_q == sqrc_pkg::sqrc_st_hold);
	// The third consecutive low edge performs the clear, and later low edges repeat it.
	wire clear_now  = low_s && ((in_count && low_cnt_q == `SQRC_CLEAR_LAST) || in_clear);
	wire boot_now   = low_s && in_clear;
	wire hold_load  = !low_s && in_hold && (rel_cnt_q == `SQRC_HOLD_LAST);
	wire pipe_adv   = in_run || hold_load;
	wire cmd_ok     = in_run;
	wire do_push    = cmd_ok && stack_push;
	wire do_pop     = cmd_ok && stack_pop;
	wire loop_is_0  = (loop_down_counter_q == '0);
	wire do_load    = cmd_ok && loop_load;
	wire do_dec     = cmd_ok && loop_dec && !loop_is_0;

	always_comb begin
		state_d   = state_q;
		low_cnt_d = low_cnt_q;
		rel_cnt_d = rel_cnt_q;
		super_d   = super_q;
		undef_d   = undef_q;
		case (state_q)
			sqrc_pkg::sqrc_st_run, sqrc_pkg::sqrc_st_super: begin
				if (low_s) begin
					state_d   = sqrc_pkg::sqrc_st_count;
					low_cnt_d = 2'h1;
				end
			end
			sqrc_pkg::sqrc_st_count: begin
				if (low_s) begin
					low_cnt_d = low_cnt_q + 2'h1;
					if (low_cnt_q == `SQRC_CLEAR_LAST) begin
						state_d = sqrc_pkg::sqrc_st_clear;
						super_d = 1'b0;
						undef_d = 1'b0;
					end
				end else if (low_cnt_q == `SQRC_SUPER_EDGES) begin
					state_d = sqrc_pkg::sqrc_st_super;
					super_d = 1'b1;
				end else begin
					// Nothing was cleared; the sequence resumes where it stood and the flag warns of it.
					state_d = super_q ? sqrc_pkg::sqrc_st_super : sqrc_pkg::sqrc_st_run;
					undef_d = 1'b1;
				end
			end
			sqrc_pkg::sqrc_st_clear: begin
				if (!low_s) begin
					state_d   = sqrc_pkg::sqrc_st_hold;
					rel_cnt_d = 2'h1;
				end
			end
			sqrc_pkg::sqrc_st_hold: begin
				if (low_s) begin
					state_d   = sqrc_pkg::sqrc_st_count;
					low_cnt_d = 2'h1;
				end else if (rel_cnt_q == `SQRC_HOLD_LAST) begin
					state_d = sqrc_pkg::sqrc_st_run;
				end else begin
					rel_cnt_d = rel_cnt_q + 2'h1;
				end
			end
			default: begin
				state_d = sqrc_pkg::sqrc_st_run;
			end
		endcase
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q   <= sqrc_pkg::sqrc_st_run;
			low_cnt_q <= 2'h0;
			rel_cnt_q <= 2'h0;
			super_q   <= 1'b0;
			undef_q   <= 1'b0;
		end else begin
			state_q   <= state_d;
			low_cnt_q <= low_cnt_d;
			rel_cnt_q <= rel_cnt_d;
			super_q   <= super_d;
			undef_q   <= undef_d;
		end
	end

	assign pipe_d = boot_now ? boot_word : pipe_adv ? next_word : pipe_q;

	assign loop_down_counter_d = clear_now ? `SQRC_LOOP_RST :
		do_load ? loop_value :
		do_dec ? loop_down_counter_q - LOOP_W'(1) : loop_down_counter_q;

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			pipe_q              <= '0;
			loop_down_counter_q <= `SQRC_LOOP_RST;
		end else begin
			pipe_q              <= pipe_d;
			loop_down_counter_q <= loop_down_counter_d;
		end
	end

	sqrc_stack #(
		.DEPTH (STACK_D),
		.WIDTH (STACK_W),
		.PW    (SP_W)
	) u_stack (
		.core_clk (core_clk),
		.rst      (rst),
		.flush    (clear_now),
		.push     (do_push),
		.pop      (do_pop),
		.wdata    (stack_wdata),
		.top      (stack_top),
		.depth    (stack_depth)
	);

	// Outputs come straight from the pipeline register, so stacked parts share one timing.
	assign ctl_out           = pipe_q[OUT_W-1:0];
	assign ctl_oe            = {OUT_W{pipe_q[OUT_W]}};
	assign loop_down_counter = loop_down_counter_q;
	assign loop_zero         = loop_is_0;
	assign supervisor_mode   = super_q;
	assign undefined_state   = undef_q;
	assign clear_active      = !in_run;

	AST_OE_ALL_OR_NONE: assert property (
		@(posedge core_clk) disable iff (rst)
		(ctl_oe == '0 && !pipe_q[OUT_W]) || (ctl_oe == '1 && pipe_q[OUT_W]))
		else $error("output enables do not follow the microword enable bit");

	AST_CLEAR_EMPTIES: assert property (
		@(posedge core_clk) disable iff (rst)
		(low_s && in_count && low_cnt_q == `SQRC_CLEAR_LAST)
		|=> (loop_down_counter_q == '0) && (stack_depth == '0) && (stack_top == '0))
		else $error("valid clear left the stack or the loop counter loaded");

	AST_PIN_LOW_CLEARS: assert property (
		@(posedge core_clk) disable iff (rst)
		(!master_clear_low) [*5] |=> in_clear && (loop_down_counter_q == '0))
		else $error("five low pin samples did not reach the clear state");

	AST_BOOT_FOURTH: assert property (
		@(posedge core_clk) disable iff (rst)
		(low_s && in_clear) |=> (pipe_q == $past(boot_word)))
		else $error("boot microword not presented while the clear is held");

	AST_HOLD_THIRD: assert property (
		@(posedge core_clk) disable iff (rst)
		(in_clear && !low_s) ##1 (in_hold && !low_s) |=> $stable(pipe_q) && in_hold)
		else $error("boot microword dropped before the third edge after release");

	AST_RUN_AFTER_THIRD: assert property (
		@(posedge core_clk) disable iff (rst)
		(in_clear && !low_s) ##1 !low_s ##1 !low_s |=> (pipe_q == $past(next_word)) && in_run)
		else $error("sequence did not resume on the third edge after release");

	AST_SUPER_ONE_EDGE: assert property (
		@(posedge core_clk) disable iff (rst)
		(in_count && !low_s && low_cnt_q == `SQRC_SUPER_EDGES) |=> supervisor_mode && !in_clear)
		else $error("single low edge did not enter supervisor mode");

	AST_TWO_NO_CLEAR: assert property (
		@(posedge core_clk) disable iff (rst)
		(in_count && !low_s && low_cnt_q == `SQRC_UNDEF_EDGES)
		|=> undefined_state && !in_clear && $stable(loop_down_counter_q))
		else $error("two low edges were taken as a valid clear");

	AST_LOOP_NO_WRAP: assert property (
		@(posedge core_clk) disable iff (rst)
		(loop_is_0 && loop_dec && !loop_load) |=> (loop_down_counter_q == '0))
		else $error("loop counter wrapped below zero");

endmodule

// ---- test/sqrc_rst_src.sv ----
`timescale 1ns/1ps

// System reset source; it drives the pin low across a chosen count of rising edges.
module sqrc_rst_src (
	input  wire logic core_clk,
	output logic      master_clear_low
);
	initial master_clear_low = 1'b1;

	task automatic pulse(input int edges);
		@(negedge core_clk);
		master_clear_low = 1'b0;
		repeat (edges) @(posedge core_clk);
		@(negedge core_clk);
		master_clear_low = 1'b1;
	endtask
endmodule

// ---- test/tb_top.sv ----
`timescale 1ns/1ps

module tb_top;
	logic        core_clk = 1'b0;
	logic        rst = 1'b1;
	logic        master_clear_low;
	logic [16:0] boot_word = 17'h1_1234;
	logic [16:0] next_word = 17'h1_a5a5;
	logic        stack_push = 1'b0;
	logic        stack_pop = 1'b0;
	logic [7:0]  stack_wdata = 8'h00;
	logic        loop_load = 1'b0;
	logic [7:0]  loop_value = 8'h00;
	logic        loop_dec = 1'b0;
	logic [15:0] ctl_out;
	logic [15:0] ctl_oe;
	logic [7:0]  stack_top;
	logic [3:0]  stack_depth;
	logic [7:0]  loop_down_counter;
	logic        loop_zero;
	logic        supervisor_mode;
	logic        undefined_state;
	logic        clear_active;
	int          mismatches = 0;
	int          tests_run = 0;

	always #5 core_clk = ~core_clk;

	sqrc_rst_src i_src (.core_clk(core_clk), .master_clear_low(master_clear_low));

	sqrc_reset_ctl i_dut (
		.core_clk(core_clk), .rst(rst), .master_clear_low(master_clear_low),
		.boot_word(boot_word), .next_word(next_word), .stack_push(stack_push),
		.stack_pop(stack_pop), .stack_wdata(stack_wdata), .loop_load(loop_load),
		.loop_value(loop_value), .loop_dec(loop_dec), .ctl_out(ctl_out), .ctl_oe(ctl_oe),
		.stack_top(stack_top), .stack_depth(stack_depth), .loop_down_counter(loop_down_counter),
		.loop_zero(loop_zero), .supervisor_mode(supervisor_mode),
		.undefined_state(undefined_state), .clear_active(clear_active)
	);

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic op(input logic pu, input logic po, input logic [7:0] wd, input logic ld, input logic de);
		@(negedge core_clk);
		stack_push = pu;
		stack_pop = po;
		stack_wdata = wd;
		loop_load = ld;
		loop_dec = de;
		@(posedge core_clk);
	endtask

	task automatic idle(input int n);
		op(1'b0, 1'b0, 8'h00, 1'b0, 1'b0);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask

	task automatic t_stack();
		for (int i = 1; i <= 16; i++) op(1'b1, 1'b0, 8'(i), 1'b0, 1'b0);
		idle(0);
		chk(stack_depth, 4'hf);
		chk(stack_top, 8'h10);
		op(1'b0, 1'b1, 8'h00, 1'b0, 1'b0);
		idle(0);
		chk(stack_top, 8'h0e);
		for (int i = 0; i < 15; i++) op(1'b0, 1'b1, 8'h00, 1'b0, 1'b0);
		idle(0);
		chk({stack_depth, stack_top}, 12'h000);
	endtask

	task automatic t_loop();
		loop_value = 8'h03;
		op(1'b0, 1'b0, 8'h00, 1'b1, 1'b0);
		for (int i = 0; i < 5; i++) op(1'b0, 1'b0, 8'h00, 1'b0, 1'b1);
		idle(0);
		chk({loop_down_counter, loop_zero}, 9'h001);
	endtask

	task automatic t_clear();
		loop_value = 8'h09;
		op(1'b1, 1'b0, 8'h5c, 1'b1, 1'b0);
		op(1'b1, 1'b0, 8'h3d, 1'b1, 1'b0);
		idle(0);
		i_src.pulse(6);
		chk({stack_depth, loop_down_counter, clear_active}, 13'h0001);
		chk(ctl_out, 16'h1234);
		chk(ctl_oe, 16'hffff);
		repeat (4) @(posedge core_clk);
		@(negedge core_clk);
		chk(ctl_out, 16'h1234);
		@(posedge core_clk);
		@(negedge core_clk);
		chk(ctl_out, 16'ha5a5);
	endtask

	task automatic t_float();
		boot_word = 17'h0_00ff;
		i_src.pulse(5);
		// With five low edges the boot word lands one edge after the pin is released.
		@(posedge core_clk);
		@(negedge core_clk);
		chk(ctl_oe, 16'h0000);
		chk(ctl_out, 16'h00ff);
		idle(6);
		chk(ctl_oe, 16'hffff);
		boot_word = 17'h1_1234;
	endtask

	task automatic t_super();
		i_src.pulse(1);
		idle(4);
		chk({supervisor_mode, clear_active}, 2'h3);
		op(1'b1, 1'b0, 8'h77, 1'b0, 1'b0);
		idle(0);
		chk(stack_depth, 4'h0);
		i_src.pulse(5);
		idle(6);
		chk({supervisor_mode, clear_active}, 2'h0);
	endtask

	task automatic t_undef();
		op(1'b1, 1'b0, 8'h42, 1'b0, 1'b0);
		idle(0);
		i_src.pulse(2);
		idle(5);
		chk({undefined_state, clear_active, stack_depth}, 6'h21);
	endtask

	task automatic final_report();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	initial begin
		#100000;
		mismatches++;
		final_report();
	end

	initial begin
		repeat (8) @(posedge core_clk);
		@(negedge core_clk);
		rst = 1'b0;
		idle(1);
		t_stack();
		t_loop();
		t_clear();
		t_float();
		t_super();
		t_undef();
		final_report();
	end
endmodule
